// >>> verilog/gpp_pkg.sv
// Constants, register map and pin carrier types for the two-port GPIO block.
// Assumes an 8-bit register port with a one-cycle read latency.
package gpp_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [3:0] ADDR_PIN_A    = 4'h0;
    localparam logic [3:0] ADDR_LAT_A    = 4'h1;
    localparam logic [3:0] ADDR_DIR_A    = 4'h2;
    localparam logic [3:0] ADDR_PIN_D    = 4'h3;
    localparam logic [3:0] ADDR_LAT_D    = 4'h4;
    localparam logic [3:0] ADDR_DIR_D    = 4'h5;
    localparam logic [3:0] ADDR_PORT_E   = 4'h6;
    localparam logic [3:0] ADDR_ANALOG   = 4'h7;
    localparam logic [3:0] ADDR_CMP      = 4'h8;
    localparam logic [3:0] ADDR_INT_STAT = 4'h9;
    localparam logic [3:0] ADDR_INT_MASK = 4'hA;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_DIR     = 8'hFF;
    localparam logic [7:0] RST_LAT     = 8'h00;
    localparam logic [7:0] RST_PORT_E  = 8'h07;
    localparam logic [4:0] RST_ANALOG  = 5'h1F;
    localparam logic [1:0] RST_CMP     = 2'h0;
    localparam logic [2:0] RST_INT     = 3'h0;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int PE_IBF  = 7;
    localparam int PE_OBF  = 6;
    localparam int PE_INPUT_OVERFLOW_FLAG = 5;
    localparam int PE_MODE = 4;
    localparam int IRQ_IN_FULL  = 0;
    localparam int IRQ_OUT_READ = 1;
    localparam int IRQ_OVERFLOW = 2;

    // Comparator pin modes.
    typedef enum logic [1:0] {
        GPP_CMP_OFF     = 2'h0,
        GPP_CMP_INPUTS  = 2'h1,
        GPP_CMP_OUTPUTS = 2'h2
    } gpp_cmp_mode_t;

    // Drive of an 8-pin port: level and output enable.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } gpp_pin_drv_t;

endpackage : gpp_pkg

// >>> verilog/gpp_ports.sv
// Two 8-bit GPIO ports with analog, comparator, oscillator, parallel slave
// port and PWM alternate functions, plus port E direction and status.
// Assumes all inputs are synchronous to core_clk.
//
// Behaviour
// RULE_01: Direction bit one floats the pin; zero drives the output latch.
// RULE_02: Pin-level read returns pins; writing it updates the output latch.
// RULE_03: Output latch is separately addressable and reads back latched value.
// RULE_04: Pins a6 and a7 follow oscillator setting; unused they read zero.
// RULE_05: Analog select bits choose analog mode for pins a0 to a3, a5.
// RULE_06: Comparator bits claim pins a0 to a5; software turns them off first.
// RULE_07: After reset a0 to a3 and a5 are analog reading zero, a4 digital.
// RULE_08: Pin a4 feeds timer0 clock input and carries comparator1 output.
// RULE_09: Direction bits control analog pins too; software keeps them input.
// RULE_10: Parallel port drives latch D on external read, accepts external writes.
// RULE_11: PWM on d5 to d7 overrides port and parallel data; shutdown floats.
// RULE_12: External write while input word unread sets overflow; software clears.
// RULE_13: Input full sets on external write, clears on CPU read; output likewise.
// RULE_14: Port D normal I/O behaves like port A.
module gpp_ports (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic [3:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    output logic                       irq,
    input  wire logic [7:0]            pin_a_in,
    output gpp_pkg::gpp_pin_drv_t      pin_a_drv,
    input  wire logic [7:0]            pin_d_in,
    output gpp_pkg::gpp_pin_drv_t      pin_d_drv,
    output logic [2:0]                 port_e_dir,
    input  wire logic                  osc_pins_as_io,
    output logic                       timer0_ext_clock_in,
    input  wire logic                  comparator1_out,
    input  wire logic                  comparator2_out,
    output logic [1:0]                 comparator_mode,
    output logic [4:0]                 analog_select,
    input  wire logic                  psp_cs_n,
    input  wire logic                  psp_rd_n,
    input  wire logic                  psp_wr_n,
    input  wire logic [2:0]            enh_pwm_en,
    input  wire logic [2:0]            enh_pwm_val,
    input  wire logic                  enh_pwm_shutdown
);

    typedef gpp_pkg::gpp_cmp_mode_t gpp_cmp_mode_t;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] dir_a_r;
    logic [7:0] lat_a_r;
    logic [7:0] dir_d_r;
    logic [7:0] lat_d_r;
    logic [7:0] psp_in_r;
    logic [2:0] dir_e_r;
    logic       ibf_r;
    logic       obf_r;
    logic       input_overflow_flag_r;
    logic       psp_mode_r;
    logic [4:0] analog_r;
    logic [1:0] cmp_r;
    logic [2:0] int_stat_r;
    logic [2:0] int_mask_r;
    logic [7:0] rdata_r;
    logic       psp_wr_act_r;
    logic       psp_rd_act_r;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic hit(input logic stb, input logic [3:0] a,
                                 input logic [3:0] want);
        hit = stb && (a == want);
    endfunction : hit

    logic [7:0] osc_mask;
    logic [7:0] analog_a;
    logic [7:0] pin_a_view;
    logic [7:0] pin_d_view;
    logic [7:0] port_e_view;
    logic       psp_wr_act;
    logic       psp_rd_act;
    logic       ext_wr_evt;
    logic       ext_rd_end;
    logic       cpu_rd_d;
    logic       cpu_wr_d;
    logic [2:0] int_evt;

    assign osc_mask = osc_pins_as_io ? 8'hFF : 8'h3F;                          // [RULE_04]
    assign analog_a = {2'h0, analog_r[4], 1'b0, analog_r[3:0]};                // [RULE_05]
    assign pin_a_view = pin_a_in & ~analog_a & osc_mask;                       // [RULE_02] [RULE_07]
    assign pin_d_view = psp_mode_r ? psp_in_r : pin_d_in;                      // [RULE_14]
    assign port_e_view = {ibf_r, obf_r, input_overflow_flag_r, psp_mode_r, 1'b0, dir_e_r};
    assign psp_wr_act = psp_mode_r && !psp_cs_n && !psp_wr_n;
    assign psp_rd_act = psp_mode_r && !psp_cs_n && !psp_rd_n;
    assign ext_wr_evt = psp_wr_act && !psp_wr_act_r;
    assign ext_rd_end = psp_rd_act_r && !psp_rd_act;
    assign cpu_rd_d = hit(reg_rd, reg_addr, gpp_pkg::ADDR_PIN_D);
    assign cpu_wr_d = hit(reg_wr, reg_addr, gpp_pkg::ADDR_PIN_D) ||
                      hit(reg_wr, reg_addr, gpp_pkg::ADDR_LAT_D);
    assign int_evt = {ext_wr_evt && ibf_r && !cpu_rd_d, ext_rd_end && obf_r, ext_wr_evt};

    // ****************************************************************
    // Port A registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_a_r <= gpp_pkg::RST_LAT;
        end else if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_PIN_A) ||
                     hit(reg_wr, reg_addr, gpp_pkg::ADDR_LAT_A)) begin
            lat_a_r <= reg_wdata;                                               // [RULE_02] [RULE_03]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_a_r <= gpp_pkg::RST_DIR;
        end else if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_DIR_A)) begin
            dir_a_r <= reg_wdata;
        end
    end

    // ****************************************************************
    // Analog and comparator control
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_r <= gpp_pkg::RST_ANALOG;                                    // [RULE_07]
            cmp_r    <= gpp_pkg::RST_CMP;
        end else begin
            if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_ANALOG)) begin
                analog_r <= reg_wdata[4:0];                                     // [RULE_05]
            end
            if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_CMP)) begin
                cmp_r <= reg_wdata[1:0];                                        // [RULE_06]
            end
        end
    end

    // ****************************************************************
    // Port D and parallel slave port
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_d_r <= gpp_pkg::RST_LAT;
            dir_d_r <= gpp_pkg::RST_DIR;
        end else begin
            if (cpu_wr_d) begin
                lat_d_r <= reg_wdata;                                           // [RULE_14]
            end
            if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_DIR_D)) begin
                dir_d_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            psp_wr_act_r <= 1'b0;
            psp_rd_act_r <= 1'b0;
            psp_in_r     <= 8'h00;
        end else begin
            psp_wr_act_r <= psp_wr_act;
            psp_rd_act_r <= psp_rd_act;
            if (ext_wr_evt) begin
                psp_in_r <= pin_d_in;                                           // [RULE_10]
            end
        end
    end

    // ****************************************************************
    // Port E direction and parallel status
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_e_r    <= gpp_pkg::RST_PORT_E[2:0];
            psp_mode_r <= gpp_pkg::RST_PORT_E[gpp_pkg::PE_MODE];
        end else if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_PORT_E)) begin
            dir_e_r    <= reg_wdata[2:0];
            psp_mode_r <= reg_wdata[gpp_pkg::PE_MODE];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ibf_r  <= gpp_pkg::RST_PORT_E[gpp_pkg::PE_IBF];
            obf_r  <= gpp_pkg::RST_PORT_E[gpp_pkg::PE_OBF];
            input_overflow_flag_r <= gpp_pkg::RST_PORT_E[gpp_pkg::PE_INPUT_OVERFLOW_FLAG];
        end else begin
            if (ext_wr_evt) begin
                ibf_r <= 1'b1;                                                  // [RULE_13]
            end else if (cpu_rd_d) begin
                ibf_r <= 1'b0;                                                  // [RULE_13]
            end
            if (cpu_wr_d && psp_mode_r) begin
                obf_r <= 1'b1;                                                  // [RULE_13]
            end else if (ext_rd_end) begin
                obf_r <= 1'b0;                                                  // [RULE_13]
            end
            if (ext_wr_evt && ibf_r && !cpu_rd_d) begin
                input_overflow_flag_r <= 1'b1;                                                 // [RULE_12]
            end else if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_PORT_E) &&
                         !reg_wdata[gpp_pkg::PE_INPUT_OVERFLOW_FLAG]) begin
                input_overflow_flag_r <= 1'b0;                                                 // [RULE_12]
            end
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_r <= gpp_pkg::RST_INT;
            int_mask_r <= gpp_pkg::RST_INT;
        end else begin
            if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_INT_STAT)) begin
                int_stat_r <= (int_stat_r & ~reg_wdata[2:0]) | int_evt;
            end else begin
                int_stat_r <= int_stat_r | int_evt;
            end
            if (hit(reg_wr, reg_addr, gpp_pkg::ADDR_INT_MASK)) begin
                int_mask_r <= reg_wdata[2:0];
            end
        end
    end

    assign irq = |(int_stat_r & int_mask_r);

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                gpp_pkg::ADDR_PIN_A:    rdata_r <= pin_a_view;                  // [RULE_02]
                gpp_pkg::ADDR_LAT_A:    rdata_r <= lat_a_r & osc_mask;          // [RULE_03] [RULE_04]
                gpp_pkg::ADDR_DIR_A:    rdata_r <= dir_a_r & osc_mask;          // [RULE_04]
                gpp_pkg::ADDR_PIN_D:    rdata_r <= pin_d_view;
                gpp_pkg::ADDR_LAT_D:    rdata_r <= lat_d_r;
                gpp_pkg::ADDR_DIR_D:    rdata_r <= dir_d_r;
                gpp_pkg::ADDR_PORT_E:   rdata_r <= port_e_view;
                gpp_pkg::ADDR_ANALOG:   rdata_r <= {3'h0, analog_r};
                gpp_pkg::ADDR_CMP:      rdata_r <= {6'h00, cmp_r};
                gpp_pkg::ADDR_INT_STAT: rdata_r <= {5'h00, int_stat_r};
                gpp_pkg::ADDR_INT_MASK: rdata_r <= {5'h00, int_mask_r};
                default:                rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    always_comb begin
        pin_a_drv.out = lat_a_r;                                                // [RULE_01]
        pin_a_drv.oe  = ~dir_a_r & osc_mask;                                    // [RULE_01] [RULE_09]
        if (gpp_cmp_mode_t'(cmp_r) == gpp_pkg::GPP_CMP_OUTPUTS) begin
            pin_a_drv.out[4] = comparator1_out;                                 // [RULE_08]
            pin_a_drv.out[5] = comparator2_out;                                 // [RULE_06]
        end
    end

    always_comb begin
        pin_d_drv.out = lat_d_r;                                                // [RULE_14]
        pin_d_drv.oe  = ~dir_d_r;                                               // [RULE_14]
        if (psp_mode_r) begin
            pin_d_drv.oe = {8{psp_rd_act}};                                     // [RULE_10]
        end
        for (int i = 0; i < 3; i++) begin
            if (enh_pwm_en[i] && !dir_d_r[i + 5]) begin
                pin_d_drv.out[i + 5] = enh_pwm_val[i];                          // [RULE_11]
                pin_d_drv.oe[i + 5]  = !enh_pwm_shutdown;                       // [RULE_11]
            end
        end
    end

    assign port_e_dir          = dir_e_r;
    assign timer0_ext_clock_in = pin_a_in[4];                                   // [RULE_08]
    assign comparator_mode     = cmp_r;
    assign analog_select       = analog_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_ext_write;
        psp_mode_r && !psp_cs_n && !psp_wr_n && !psp_wr_act_r;
    endsequence

    sequence s_cpu_read_d;
        reg_rd && reg_addr == gpp_pkg::ADDR_PIN_D;
    endsequence

    chk_dir_drives_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_01]
        !dir_a_r[1] |-> pin_a_drv.oe[1] && pin_a_drv.out[1] == lat_a_r[1])
        else $error("pin a1 not driven from its latch");

    chk_pin_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_02]
        reg_rd && reg_addr == gpp_pkg::ADDR_PIN_A |=> reg_rdata[4] == $past(pin_a_in[4]))
        else $error("pin a4 level not returned");

    chk_pin_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_02]
        reg_wr && reg_addr == gpp_pkg::ADDR_PIN_A |=> lat_a_r == $past(reg_wdata))
        else $error("pin register write missed the latch");

    chk_latch_back_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_03]
        reg_rd && reg_addr == gpp_pkg::ADDR_LAT_A |=> reg_rdata[5:0] == $past(lat_a_r[5:0]))
        else $error("latch readback differs");

    chk_osc_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_04]
        reg_rd && !osc_pins_as_io && reg_addr == gpp_pkg::ADDR_DIR_A |=> reg_rdata[7:6] == 2'h0)
        else $error("oscillator pins not reading zero");

    chk_analog_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_07]
        reg_rd && reg_addr == gpp_pkg::ADDR_PIN_A && analog_r[0] |=> reg_rdata[0] == 1'b0)
        else $error("analog pin a0 read nonzero");

    chk_cmp_out_a4: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_08]
        cmp_r == 2'h2 && !dir_a_r[4] |-> pin_a_drv.out[4] == comparator1_out)
        else $error("comparator1 output not on pin a4");

    chk_psp_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_10]
        psp_rd_act |-> pin_d_drv.oe[0] && pin_d_drv.out[0] == lat_d_r[0])
        else $error("parallel read data not driven");

    chk_pwm_override: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_11]
        enh_pwm_en[0] && !dir_d_r[5] && !enh_pwm_shutdown
        |-> pin_d_drv.oe[5] && pin_d_drv.out[5] == enh_pwm_val[0])
        else $error("PWM did not override pin d5");

    chk_overflow_set: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_12]
        s_ext_write ##0 (ibf_r && !reg_rd) |=> input_overflow_flag_r && int_stat_r[gpp_pkg::IRQ_OVERFLOW])
        else $error("overflow not flagged");

    chk_ibf_cycle: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_13]
        s_ext_write |=> ibf_r && int_stat_r[gpp_pkg::IRQ_IN_FULL])
        else $error("input full flow broken");

    chk_ibf_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE_13]
        s_cpu_read_d ##0 !(psp_mode_r && !psp_cs_n && !psp_wr_n && !psp_wr_act_r) |=> !ibf_r)
        else $error("input full not cleared by read");

endmodule : gpp_ports

// >>> verif/gpp_pins_model.sv
// Pins and parallel host standing outside the GPIO ports.
// Assumes the bench sets ext_a and calls the host tasks.
module gpp_pins_model (
    input  wire logic                  core_clk,
    input  wire gpp_pkg::gpp_pin_drv_t pin_a_drv,
    input  wire gpp_pkg::gpp_pin_drv_t pin_d_drv,
    input  wire logic [7:0]            ext_a,
    output logic [7:0]                 pin_a_in,
    output logic [7:0]                 pin_d_in,
    output logic                       psp_cs_n,
    output logic                       psp_rd_n,
    output logic                       psp_wr_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] host_d = 8'h5A;
    // A driven pin shows the drive, a floating one the outside level.
    assign pin_a_in = (pin_a_drv.oe & pin_a_drv.out) | (~pin_a_drv.oe & ext_a);
    assign pin_d_in = (pin_d_drv.oe & pin_d_drv.out) | (~pin_d_drv.oe & host_d);
    initial begin
        psp_cs_n = 1'b1;
        psp_rd_n = 1'b1;
        psp_wr_n = 1'b1;
    end
    // The host selects and strobes for one access, data held throughout.
    task automatic host_begin(input logic wr, input logic [7:0] d);
        @(posedge core_clk);
        host_d   <= d;
        psp_cs_n <= 1'b0;
        psp_wr_n <= ~wr;
        psp_rd_n <= wr;
    endtask : host_begin
    // Release between accesses; released data lines show the inverse level.
    task automatic host_end;
        @(posedge core_clk);
        psp_cs_n <= 1'b1;
        psp_wr_n <= 1'b1;
        psp_rd_n <= 1'b1;
        host_d   <= ~host_d;
    endtask : host_end
endmodule : gpp_pins_model

// >>> verif/gpp_ports_tb.sv
// Self-checking bench for the two-port GPIO block.
// Assumes the pin model stands for the pins and the parallel host.
module gpp_ports_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  core_clk = 1'b0;
    logic                  rst_n, reg_wr, reg_rd, irq, osc_pins_as_io, timer0_ext_clock_in;
    logic                  comparator1_out, comparator2_out, enh_pwm_shutdown;
    logic                  psp_cs_n, psp_rd_n, psp_wr_n;
    logic [3:0]            reg_addr;
    logic [7:0]            reg_wdata, reg_rdata, pin_a_in, pin_d_in, ext_a, rd_v, dir, lat;
    logic [2:0]            port_e_dir, enh_pwm_en, enh_pwm_val;
    logic [1:0]            comparator_mode;
    logic [4:0]            analog_select;
    gpp_pkg::gpp_pin_drv_t pin_a_drv, pin_d_drv;
    int                    n_fail = 0;
    int                    checked = 0;
    int                    seed;
    always #50 core_clk = ~core_clk;
    gpp_ports dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq, .pin_a_in, .pin_a_drv, .pin_d_in, .pin_d_drv, .port_e_dir, .osc_pins_as_io,
        .timer0_ext_clock_in, .comparator1_out, .comparator2_out, .comparator_mode,
        .analog_select, .psp_cs_n, .psp_rd_n, .psp_wr_n, .enh_pwm_en, .enh_pwm_val,
        .enh_pwm_shutdown);
    gpp_pins_model m (.core_clk, .pin_a_drv, .pin_d_drv, .ext_a, .pin_a_in, .pin_d_in,
        .psp_cs_n, .psp_rd_n, .psp_wr_n);
    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rchk
    function automatic logic [7:0] pins(input logic [7:0] d, l, x);
        return (~d & l) | (d & x);
    endfunction : pins
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        #2ms;
        n_fail++;
        end_sim();
    end
    initial begin
        seed = $urandom(9);
        {rst_n, reg_wr, reg_rd, osc_pins_as_io, comparator1_out, comparator2_out} = '0;
        {reg_addr, reg_wdata, enh_pwm_en, enh_pwm_val, enh_pwm_shutdown} = '0;
        ext_a = 8'hFF;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(gpp_pkg::ADDR_DIR_A, 8'h3F);
        rchk(gpp_pkg::ADDR_PORT_E, 8'h07);
        rchk(gpp_pkg::ADDR_ANALOG, 8'h1F);
        rchk(gpp_pkg::ADDR_PIN_A, 8'h10);
        rchk(4'hB, 8'h00);
        chk({5'h0, port_e_dir}, 8'h07);
        osc_pins_as_io <= 1'b1;
        wr(gpp_pkg::ADDR_ANALOG, 8'h00);
        wr(gpp_pkg::ADDR_CMP, 8'h00);
        for (int i = 0; i < 8; i++) begin
            dir = $urandom;
            lat = $urandom;
            ext_a <= $urandom;
            m.host_d <= $urandom;
            wr(gpp_pkg::ADDR_PIN_A, lat);
            wr(gpp_pkg::ADDR_DIR_A, dir);
            rchk(gpp_pkg::ADDR_LAT_A, lat);
            rchk(gpp_pkg::ADDR_PIN_A, pins(dir, lat, ext_a));
            chk(pin_a_drv.oe, ~dir);
            chk(pin_a_drv.out & ~dir, lat & ~dir);
            chk({7'h0, timer0_ext_clock_in}, {7'h0, pin_a_in[4]});
            wr(gpp_pkg::ADDR_PIN_D, lat);
            wr(gpp_pkg::ADDR_DIR_D, dir);
            rchk(gpp_pkg::ADDR_PIN_D, pins(dir, lat, m.host_d));
            chk(pin_d_drv.oe, ~dir);
        end
        osc_pins_as_io <= 1'b0;
        rchk(gpp_pkg::ADDR_LAT_A, lat & 8'h3F);
        rchk(gpp_pkg::ADDR_DIR_A, dir & 8'h3F);
        chk(pin_a_drv.oe & 8'hC0, 8'h00);
        osc_pins_as_io <= 1'b1;
        wr(gpp_pkg::ADDR_DIR_A, 8'h00);
        wr(gpp_pkg::ADDR_CMP, {6'h0, gpp_pkg::GPP_CMP_OUTPUTS});
        for (int c = 0; c < 2; c++) begin
            comparator1_out <= c[0];
            comparator2_out <= !c[0];
            @(posedge core_clk);
            #1;
            chk({7'h0, pin_a_drv.out[4]}, {7'h0, c[0]});
            chk({7'h0, pin_a_drv.out[5]}, {7'h0, !c[0]});
            chk({6'h0, comparator_mode}, 8'h02);
        end
        wr(gpp_pkg::ADDR_CMP, 8'h00);
        wr(gpp_pkg::ADDR_DIR_A, 8'hFF);
        wr(gpp_pkg::ADDR_ANALOG, 8'h11);
        chk({3'h0, analog_select}, 8'h11);
        rchk(gpp_pkg::ADDR_PIN_A, ext_a & 8'hDE);
        wr(gpp_pkg::ADDR_DIR_D, 8'hFF);
        wr(gpp_pkg::ADDR_PORT_E, 8'h17);
        m.host_begin(1'b1, 8'h3C);
        m.host_end();
        m.host_begin(1'b1, 8'hC5);
        m.host_end();
        rchk(gpp_pkg::ADDR_PORT_E, 8'hB7);
        chk({7'h0, irq}, 8'h00);
        wr(gpp_pkg::ADDR_INT_MASK, 8'h07);
        chk({7'h0, irq}, 8'h01);
        rchk(gpp_pkg::ADDR_PIN_D, 8'hC5);
        rchk(gpp_pkg::ADDR_PORT_E, 8'h37);
        wr(gpp_pkg::ADDR_PORT_E, 8'h17);
        lat = $urandom;
        wr(gpp_pkg::ADDR_LAT_D, lat);
        rchk(gpp_pkg::ADDR_PORT_E, 8'h57);
        wr(gpp_pkg::ADDR_DIR_D, 8'h1F);
        enh_pwm_en <= 3'h7;
        enh_pwm_val <= $urandom;
        m.host_begin(1'b0, 8'h00);
        @(posedge core_clk);
        #1;
        chk(pin_d_drv.oe, 8'hFF);
        chk(pin_d_drv.out, {enh_pwm_val, lat[4:0]});
        m.host_end();
        repeat (2) @(posedge core_clk);
        rchk(gpp_pkg::ADDR_PORT_E, 8'h17);
        rchk(gpp_pkg::ADDR_INT_STAT, 8'h07);
        wr(gpp_pkg::ADDR_INT_STAT, 8'h07);
        rchk(gpp_pkg::ADDR_INT_STAT, 8'h00);
        chk({7'h0, irq}, 8'h00);
        wr(gpp_pkg::ADDR_PORT_E, 8'h07);
        wr(gpp_pkg::ADDR_DIR_D, 8'h00);
        enh_pwm_shutdown <= 1'b1;
        @(posedge core_clk);
        #1;
        chk(pin_d_drv.oe, 8'h1F);
        end_sim();
    end
endmodule : gpp_ports_tb
